// [core/tprs_pkg.sv]
package tprs_pkg;

    // mode setting codes
    localparam logic [2:0] MODE_DISABLED = 3'h0;
    localparam logic [2:0] MODE_OFF      = 3'h1;
    localparam logic [2:0] MODE_ONE_SHOT = 3'h3;
    localparam logic [2:0] MODE_TWO_SHOT = 3'h6;

    // setting field, timer and prescaler widths
    localparam int unsigned SET_W    = 8;
    localparam int unsigned DWELL_W  = 5;
    localparam int unsigned TIMER_W  = 16;
    localparam int unsigned PRESC_W  = 24;

    // timing base: one timer unit is 10 ms
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned UNIT_TIME_NS  = 10000000;
    localparam int unsigned UNIT_CYCLES   = UNIT_TIME_NS / CLK_PERIOD_NS;

    // setting scale factors in timer units
    localparam logic [TIMER_W-1:0] UNITS_PER_CS = 16'h0001;
    localparam logic [TIMER_W-1:0] UNITS_PER_DS = 16'h000A;
    localparam logic [TIMER_W-1:0] UNITS_PER_S  = 16'h0064;

    // sequencer states
    typedef enum logic [2:0] {
        TPRS_IDLE,
        TPRS_DELAY,
        TPRS_HOLD,
        TPRS_CLOSE,
        TPRS_RECLAIM,
        TPRS_LOCKOUT
    } tprs_state_t;

endpackage : tprs_pkg

// [core/tprs_timer.sv]
`timescale 1ns/1ns
module tprs_timer
    import tprs_pkg::*;
(
    input  wire logic               sys_clk_i,
    input  wire logic               reset_i,
    input  wire logic               load_i,
    input  wire logic [TIMER_W-1:0] load_value_i,
    input  wire logic               unit_tick_i,
    output logic                    expired_o
);
    import tprs_pkg::*;

    typedef struct packed {
        logic [TIMER_W-1:0] count;
    } tprs_timer_regs_t;

    tprs_timer_regs_t r;
    tprs_timer_regs_t next_r;

    // load wins over counting; stops at zero
    always_comb begin
        next_r = r;
        if (load_i) begin
            next_r.count = load_value_i;
        end else if (unit_tick_i && (r.count != 16'h0000)) begin
            next_r.count = r.count - 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // plain count test: gating with load would loop through the sequencer's load decision
    assign expired_o = (r.count == 16'h0000);

endmodule : tprs_timer

// [core/tprs_core.sv]
`timescale 1ns/1ns
module tprs_core
    import tprs_pkg::*;
#(
    parameter int unsigned UNIT_TICK_CYCLES = UNIT_CYCLES
) (
    input  wire logic               sys_clk_i,
    input  wire logic               reset_i,
    input  wire logic [2:0]         reclose_mode_select_i,
    input  wire logic [SET_W-1:0]   first_attempt_delay_i,
    input  wire logic [SET_W-1:0]   second_attempt_delay_i,
    input  wire logic               hold_enable_i,
    input  wire logic [SET_W-1:0]   inhibit_wait_limit_i,
    input  wire logic [DWELL_W-1:0] close_pulse_duration_i,
    input  wire logic [SET_W-1:0]   reclaim_interval_i,
    input  wire logic               trip_i,
    input  wire logic               inhibit_contact_input_i,
    input  wire logic               lockout_clear_i,
    output logic                    close_breaker_o,
    output logic                    zone_one_reach_reset_out_o,
    output logic                    lockout_o,
    output logic                    in_progress_o,
    output logic                    second_attempt_o
);
    import tprs_pkg::*;

    // every register of the sequencer except the timer count, which sits in tprs_timer, in one word
    typedef struct packed {
        tprs_state_t        state;
        logic               second;
        logic               close;
        logic               zone_one_reach_reset_out;
        logic               lockout;
        logic [PRESC_W-1:0] presc;
        logic               unit_tick;
        logic               trip_meta;
        logic               trip_sync;
        logic               trip_prev;
        logic               inh_meta;
        logic               inh_sync;
        logic               clr_meta;
        logic               clr_sync;
    } tprs_core_regs_t;

    // state word, its next value and the shared timer handshake
    tprs_core_regs_t    r;
    tprs_core_regs_t    next_r;
    logic               timer_load;
    logic [TIMER_W-1:0] timer_value;
    logic               timer_expired;

    // setting value times its unit, in 10 ms timer units
    function automatic logic [TIMER_W-1:0] to_units(input logic [SET_W-1:0] v,
                                                    input logic [TIMER_W-1:0] k);
        to_units = TIMER_W'(v) * k;
    endfunction : to_units

    // modes that run a reclose sequence
    function automatic logic mode_enabled(input logic [2:0] m);
        mode_enabled = (m == MODE_ONE_SHOT) || (m == MODE_TWO_SHOT);
    endfunction : mode_enabled

    // mode that grants a second attempt
    function automatic logic mode_two_shot(input logic [2:0] m);
        mode_two_shot = (m == MODE_TWO_SHOT);
    endfunction : mode_two_shot

    // shared down counter for every delay of the sequence
    tprs_timer u_timer (
        .sys_clk_i    (sys_clk_i),
        .reset_i      (reset_i),
        .load_i       (timer_load),
        .load_value_i (timer_value),
        .unit_tick_i  (r.unit_tick),
        .expired_o    (timer_expired)
    );

    // sequencer, synchronisers and 10 ms prescaler
    always_comb begin
        logic enabled;
        logic trip_edge;
        enabled     = 1'b0;
        trip_edge   = 1'b0;
        next_r      = r;
        timer_load  = 1'b0;
        timer_value = '0;

        // two-stage synchronisers for pins
        next_r.trip_meta = trip_i;
        next_r.trip_sync = r.trip_meta;
        next_r.trip_prev = r.trip_sync;
        next_r.inh_meta  = inhibit_contact_input_i;
        next_r.inh_sync  = r.inh_meta;
        next_r.clr_meta  = lockout_clear_i;
        next_r.clr_sync  = r.clr_meta;
        trip_edge        = r.trip_sync && !r.trip_prev;

        // prescaler gives one pulse per timer unit
        if (r.presc == PRESC_W'(UNIT_TICK_CYCLES - 1)) begin
            next_r.presc     = '0;
            next_r.unit_tick = 1'b1;
        end else begin
            next_r.presc     = r.presc + 24'h000001;
            next_r.unit_tick = 1'b0;
        end

        enabled = mode_enabled(reclose_mode_select_i);

        case (r.state)
            TPRS_IDLE: begin
                if (enabled && trip_edge) begin
                    next_r.state  = TPRS_DELAY;
                    next_r.second = 1'b0;
                    timer_load    = 1'b1;
                    timer_value   = to_units(first_attempt_delay_i, UNITS_PER_CS);
                end
            end
            TPRS_DELAY: begin
                if (timer_expired) begin
                    // inhibit sampled right before closing
                    if (!r.inh_sync) begin
                        next_r.state = TPRS_CLOSE;
                        timer_load   = 1'b1;
                        timer_value  = to_units(SET_W'(close_pulse_duration_i),
                                                UNITS_PER_DS);
                    end else if (hold_enable_i) begin
                        next_r.state = TPRS_HOLD;
                        timer_load   = 1'b1;
                        timer_value  = to_units(inhibit_wait_limit_i, UNITS_PER_S);
                    end else begin
                        next_r.state = TPRS_LOCKOUT;
                    end
                end
            end
            TPRS_HOLD: begin
                if (!r.inh_sync) begin
                    next_r.state = TPRS_CLOSE;
                    timer_load   = 1'b1;
                    timer_value  = to_units(SET_W'(close_pulse_duration_i), UNITS_PER_DS);
                end else if (timer_expired) begin
                    next_r.state = TPRS_LOCKOUT;
                end
            end
            TPRS_CLOSE: begin
                if (timer_expired) begin
                    next_r.state = TPRS_RECLAIM;
                    timer_load   = 1'b1;
                    timer_value  = to_units(reclaim_interval_i, UNITS_PER_S);
                end
            end
            TPRS_RECLAIM: begin
                if (trip_edge) begin
                    if (mode_two_shot(reclose_mode_select_i) && !r.second) begin
                        next_r.state  = TPRS_DELAY;
                        next_r.second = 1'b1;
                        timer_load    = 1'b1;
                        timer_value   = to_units(second_attempt_delay_i, UNITS_PER_S);
                    end else begin
                        next_r.state = TPRS_LOCKOUT;
                    end
                end else if (timer_expired) begin
                    next_r.state  = TPRS_IDLE;
                    next_r.second = 1'b0;
                end
            end
            TPRS_LOCKOUT: begin
                if (r.clr_sync) begin
                    next_r.state  = TPRS_IDLE;
                    next_r.second = 1'b0;
                end
            end
            default: begin
                next_r.state = TPRS_IDLE;
            end
        endcase

        // leaving the reclosing modes abandons any sequence
        if (!enabled) begin
            next_r.state  = TPRS_IDLE;
            next_r.second = 1'b0;
        end

        // close and lockout follow the next state so close starts with the state; the zone reset output follows the mode
        next_r.close   = (next_r.state == TPRS_CLOSE);
        next_r.lockout = (next_r.state == TPRS_LOCKOUT);
        next_r.zone_one_reach_reset_out    = (reclose_mode_select_i == MODE_OFF);
    end

    // register the whole state word
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            r       <= '0;
            r.state <= TPRS_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from registers, except in_progress_o, decoded from state and lockout
    assign close_breaker_o            = r.close;
    assign zone_one_reach_reset_out_o = r.zone_one_reach_reset_out;
    assign lockout_o                  = r.lockout;
    assign in_progress_o              = (r.state != TPRS_IDLE) && !r.lockout;
    assign second_attempt_o           = r.second;

endmodule : tprs_core

// [verif/tprs_core_properties.sv]
`timescale 1ns/1ns
module tprs_core_properties
    import tprs_pkg::*;
#(
    parameter int unsigned UNIT_TICK_CYCLES = 4
) (
    input wire logic               sys_clk_i,
    input wire logic               reset_i,
    input wire logic [2:0]         reclose_mode_select_i,
    input wire logic [DWELL_W-1:0] close_pulse_duration_i,
    input wire logic               inhibit_contact_input_i,
    input wire logic               close_breaker_o,
    input wire logic               zone_one_reach_reset_out_o,
    input wire logic               lockout_o,
    input wire logic               in_progress_o,
    input wire logic               second_attempt_o
);
    localparam int U = int'(UNIT_TICK_CYCLES);
    int hi_cnt;
    int dw;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // cycles that close has stood high
    always_ff @(posedge sys_clk_i) begin
        hi_cnt <= (reset_i || !close_breaker_o) ? 0 : hi_cnt + 1;
    end
    assign dw = int'(close_pulse_duration_i) * 10 * U;
    chk_disabled_all_low: assert property (
        reclose_mode_select_i == MODE_DISABLED |=> !close_breaker_o && !lockout_o
        && !in_progress_o && !zone_one_reach_reset_out_o) else $error("output on while disabled");
    chk_zone_follows_mode: assert property (
        !$past(reset_i) |-> zone_one_reach_reset_out_o == ($past(reclose_mode_select_i) == MODE_OFF))
        else $error("zone reset output wrong");
    chk_off_no_action: assert property (
        reclose_mode_select_i == MODE_OFF |=> !close_breaker_o && !lockout_o)
        else $error("action while turned off");
    chk_lockout_no_close: assert property (
        lockout_o |-> !close_breaker_o) else $error("close during lockout");
    chk_close_dwell_len: assert property (
        $fell(close_breaker_o) |-> hi_cnt >= dw - U && hi_cnt <= dw + U + 2)
        else $error("close pulse length wrong");
    // pin to sync stages to decision to close register: the deciding pin value is three back
    chk_close_inhibit_open: assert property (
        $rose(close_breaker_o) |-> !$past(inhibit_contact_input_i, 3))
        else $error("close with inhibit on");
    chk_lockout_no_pulse: assert property (
        $rose(lockout_o) |-> !close_breaker_o && !$past(close_breaker_o))
        else $error("lockout entered from close");
    chk_second_two_shot: assert property (
        $rose(second_attempt_o) |-> $past(reclose_mode_select_i) == MODE_TWO_SHOT)
        else $error("second attempt outside two shot");
    chk_close_in_sequence: assert property (
        close_breaker_o |-> in_progress_o) else $error("close outside sequence");
    cov_close: cover property ($rose(close_breaker_o));
    cov_lockout: cover property ($rose(lockout_o));
    cov_second: cover property ($rose(second_attempt_o));
endmodule : tprs_core_properties

bind tprs_core tprs_core_properties #(.UNIT_TICK_CYCLES(UNIT_TICK_CYCLES)) u_props (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reclose_mode_select_i(reclose_mode_select_i),
    .close_pulse_duration_i(close_pulse_duration_i),
    .inhibit_contact_input_i(inhibit_contact_input_i), .close_breaker_o(close_breaker_o),
    .zone_one_reach_reset_out_o(zone_one_reach_reset_out_o), .lockout_o(lockout_o),
    .in_progress_o(in_progress_o), .second_attempt_o(second_attempt_o));

// [verif/tprs_breaker_model.sv]
`timescale 1ns/1ns
module tprs_breaker_model (
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    input  wire logic close_i,
    output int        closes_o,
    output int        width_o
);
    int run;
    // count close commands and measure each one
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            closes_o <= 0;
            width_o <= 0;
            run <= 0;
        end else if (close_i === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            closes_o <= closes_o + 1;
            width_o <= run;
            run <= 0;
        end
    end
endmodule : tprs_breaker_model

// [verif/tprs_core_test.sv]
`timescale 1ns/1ns
module tprs_core_test;
    import tprs_pkg::*;
    localparam int U = 4;
    logic       clk, rst, trip, inh, hold, clr, close, zone_one_reach_reset_out, lock, busy, sec;
    logic [2:0] mode;
    logic [2:0] mlist [3] = '{MODE_DISABLED, MODE_OFF, 3'h2};
    logic [7:0] first, seed;
    logic [4:0] dwell;
    int         n_mismatch, tests_run, closes, width, exp_close, f, n;
    tprs_core #(.UNIT_TICK_CYCLES(U)) DUT (
        .sys_clk_i(clk), .reset_i(rst), .reclose_mode_select_i(mode),
        .first_attempt_delay_i(first), .second_attempt_delay_i(8'h01), .hold_enable_i(hold),
        .inhibit_wait_limit_i(8'h01), .close_pulse_duration_i(dwell), .reclaim_interval_i(8'h01),
        .trip_i(trip), .inhibit_contact_input_i(inh), .lockout_clear_i(clr),
        .close_breaker_o(close), .zone_one_reach_reset_out_o(zone_one_reach_reset_out), .lockout_o(lock),
        .in_progress_o(busy), .second_attempt_o(sec));
    tprs_breaker_model BRK (.sys_clk_i(clk), .reset_i(rst), .close_i(close),
        .closes_o(closes), .width_o(width));
    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic summarize();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    function automatic logic hit(input int s);
        case (s)
            0: return close;
            1: return lock;
            2: return !close;
            3: return !lock;
            default: return !busy;
        endcase
    endfunction : hit
    task automatic wait_for(input int s, input int lim);
        n = 0;
        while (hit(s) !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
        // a limit that runs out is a failure of its own
        if (hit(s) !== 1'b1) begin
            n_mismatch++;
            $display("mismatch %0t wait limit %0d", $time, s);
        end
    endtask : wait_for
    // 8-bit shift register for random settings
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    // new random first delay and dwell while idle, then a trip pulse
    task automatic start();
        seed = lfsr(seed);
        if (busy === 1'b0) begin
            f     = int'(seed[1:0]) + 1;
            first = 8'(f);
            dwell = 5'(seed[3:2]) + 5'h01;
        end
        tick(4);
        trip = 1'b1;
        tick(4);
        trip = 1'b0;
    endtask : start
    task automatic close_cycle(input int d);
        int w;
        w = int'(dwell) * 10 * U;
        wait_for(0, d + 3 * U + 20);
        chk(n >= d - U + 1 && n <= d, "close delay");
        exp_close++;
        wait_for(2, w + 2 * U);
        tick(2);
        chk(closes == exp_close, "close count");
        chk(width > w - U && width <= w, "close pulse");
    endtask : close_cycle
    task automatic lock_chk();
        wait_for(1, 20);
        chk(lock === 1'b1 && closes == exp_close, "no lockout");
    endtask : lock_chk
    task automatic clear();
        clr = 1'b1;
        wait_for(3, 20);
        chk(lock === 1'b0 && busy === 1'b0, "lockout clear");
        clr = 1'b0;
        tick(4);
    endtask : clear
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        {n_mismatch, tests_run, exp_close} = '0;
        {trip, inh, hold, clr, rst, mode, first, seed} = {5'h01, MODE_DISABLED, 8'h01, 8'h0D};
        dwell = 5'h02;
        tick(2);
        rst = 1'b0;
        chk({close, zone_one_reach_reset_out, lock, busy, sec} === 5'h00, "reset outputs");
        foreach (mlist[i]) begin
            mode = mlist[i];
            start();
            tick(10 * U);
            chk(zone_one_reach_reset_out === (mode == MODE_OFF), "idle zone output");
            chk({close, lock, busy} === 3'h0, "idle mode");
        end
        mode = MODE_TWO_SHOT;
        start();
        close_cycle(f * U);
        tick(20);
        start();
        close_cycle(100 * U);
        chk(sec === 1'b1, "second attempt");
        start();
        lock_chk();
        tick(500);
        lock_chk();
        clear();
        mode = MODE_ONE_SHOT;
        start();
        close_cycle(f * U);
        start();
        lock_chk();
        clear();
        start();
        close_cycle(f * U);
        wait_for(5, 500);
        chk(n >= 100 * U - 8 && n <= 100 * U + U + 4, "reclaim time");
        inh = 1'b1;
        start();
        lock_chk();
        clear();
        hold = 1'b1;
        start();
        tick(f * U + 40);
        chk(close === 1'b0 && busy === 1'b1, "close while held");
        inh = 1'b0;
        wait_for(0, 12);
        chk(close === 1'b1 && n <= 8, "close on inhibit drop");
        exp_close++;
        wait_for(5, 900);
        inh = 1'b1;
        start();
        wait_for(1, f * U + 100 * U + 40);
        chk(n >= f * U + 100 * U - 4, "hold time short");
        chk(n <= f * U + 100 * U + 2 * U + 8, "hold time long");
        chk(closes == exp_close, "close count");
        clear();
        summarize();
    end
endmodule : tprs_core_test
